/* rtl/energy_out_pkg.sv */
// constants and types shared by the energy pulse output stage
package energy_out_pkg;
    localparam logic [7:0]  OFS_CONFIG  = 8'h00;
    localparam logic [7:0]  OFS_MODES   = 8'h04;
    localparam logic [7:0]  OFS_CYCLES  = 8'h08;
    localparam logic [7:0]  OFS_NOLOAD  = 8'h0C;
    localparam logic [7:0]  OFS_PWIDTH  = 8'h10;
    localparam logic [7:0]  OFS_PRATE   = 8'h14;
    localparam logic [7:0]  OFS_STATUS  = 8'h18;
    localparam logic [7:0]  OFS_MASK    = 8'h1C;
    localparam logic [7:0]  OFS_ACTIVE  = 8'h40;
    localparam logic [3:0]  PAGE_DUR    = 4'h2;
    localparam logic [3:0]  PAGE_LEVEL  = 4'h3;
    localparam int          CFG_NONINV  = 4;
    localparam int          CFG_IRQ_POLARITY_INVERT    = 5;
    localparam int          CFG_IRQ_PULSE_SELECT   = 6;
    localparam int          MODE_A_LSB  = 0;
    localparam int          MODE_B_LSB  = 2;
    localparam int          MODE_C_LSB  = 4;
    localparam int          ST_LOWRATE  = 4;
    localparam int          ST_PFAIL    = 5;
    localparam logic [6:0]  RST_CONFIG  = 7'h01;
    localparam logic [5:0]  RST_MODES   = 6'h00;
    localparam logic [15:0] RST_CYCLES  = 16'h0FA0;
    localparam logic [15:0] MIN_CYCLES  = 16'h000A;
    localparam logic [15:0] RST_PWIDTH  = 16'h0001;
    localparam logic [15:0] RST_PRATE   = 16'h0CCD;
    localparam logic [23:0] RST_NOLOAD  = 24'h000000;
    localparam logic [5:0]  RST_MASK    = 6'h00;
    localparam logic [15:0] RST_DUR     = 16'h0000;
    localparam logic [23:0] RST_LEVEL   = 24'h000000;
    localparam logic [9:0]  OWR_LAST    = 10'h3FF;
    localparam logic        IRQ_LAST    = 1'b1;
    typedef enum logic [1:0] {IRQ_IDLE, IRQ_PULSE, IRQ_HELD} irq_state_e;
endpackage

/* rtl/sag_fault_detect.sv */
// windowed sag or fault detector for one measurement channel
`timescale 1ns/100ps
module sag_fault_detect
    import energy_out_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // sample stream
    input  wire logic               sampleStb,
    input  wire logic signed [23:0] sample,
    // settings
    input  wire logic [23:0]        threshold,
    input  wire logic [15:0]        duration,
    // result
    output logic                    faultSet
);
    logic [15:0] winCnt_r, winCnt_nxt, above_r, above_nxt, below_r, below_nxt;
    logic        faultSet_nxt;
    logic [23:0] mag;
    logic [15:0] newAbove, newBelow;

    always_comb begin
        mag = sample[23] ? 24'(-sample) : 24'(sample);
        newBelow = below_r + 16'(mag < threshold);
        newAbove = above_r + 16'(mag >= threshold);
        winCnt_nxt = winCnt_r;
        above_nxt = above_r;
        below_nxt = below_r;
        faultSet_nxt = 1'b0;
        if (duration == 16'h0000) begin
            winCnt_nxt = 16'h0000;
            above_nxt = 16'h0000;
            below_nxt = 16'h0000;
        end else if (sampleStb) begin
            if (winCnt_r >= duration - 16'h0001) begin
                faultSet_nxt = newBelow > newAbove;
                winCnt_nxt = 16'h0000;
                above_nxt = 16'h0000;
                below_nxt = 16'h0000;
            end else begin
                winCnt_nxt = winCnt_r + 16'h0001;
                above_nxt = newAbove;
                below_nxt = newBelow;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            winCnt_r <= 16'h0000;
            above_r <= 16'h0000;
            below_r <= 16'h0000;
            faultSet <= 1'b0;
        end else begin
            winCnt_r <= winCnt_nxt;
            above_r <= above_nxt;
            below_r <= below_nxt;
            faultSet <= faultSet_nxt;
        end
    end

    detector_off_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(duration) == 16'h0000 |-> !faultSet)
        else $error("detector flagged while disabled");
    set_on_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
        faultSet |-> $past(sampleStb) && $past(winCnt_r) >= $past(duration) - 16'h0001)
        else $error("flag set outside window end");
endmodule

/* rtl/energy_output_stage.sv */
// energy pulse pins, interrupt pin, clock divider and sag/fault flags with apb registers
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
// Overview of operation
// - internal clock is crystal divided by K, 0=16
// - cpu clock inverted unless noninvert bit set
// - two bits pick irq level/pulse and polarity
// - irq pulse lasts two divided clock cycles
// - averaging window from cycle count, min 10
// - reset: A active, B sign, C reactive
// - B selector: sign, apparent, unused, enable A-mode
// - C selector outside A-mode: reactive, power fail, v1 sign, apparent
// - A-mode: A/B carry both channels of one type
// - small active and reactive pulse values forced zero
// - width and rate ignored by steady pins
// - pulse lasts width times sample period, default 1
// - pulse frequency is rate times value over 2^40 per sample
// - zero duration disables a detector
// - below count over above count sets flag
// - irq asserts on any enabled status bit
// - pulse values are two-channel sum halved
module energy_output_stage
    import energy_out_pkg::*;
(
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst,
    // apb slave
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // pins
    input  wire logic               crystalInput,
    input  wire logic               powerFailMonitor,
    output logic                    procClockOut,
    output logic                    pulsePinA_n,
    output logic                    pulsePinB_n,
    output logic                    pulsePinC_n,
    output logic                    irqPin,
    // averaged results per channel
    input  wire logic signed [23:0] active1,
    input  wire logic signed [23:0] active2,
    input  wire logic signed [23:0] apparent1,
    input  wire logic signed [23:0] apparent2,
    input  wire logic signed [23:0] reactive1,
    input  wire logic signed [23:0] reactive2,
    input  wire logic signed [23:0] wideband1,
    input  wire logic signed [23:0] wideband2,
    // instantaneous samples
    input  wire logic signed [23:0] volt1Sample,
    input  wire logic signed [23:0] volt2Sample,
    input  wire logic signed [23:0] curr1Sample,
    input  wire logic signed [23:0] curr2Sample
);
    function automatic logic [4:0] divisorOf(input logic [3:0] k);
        return (k == 4'h0) ? 5'h10 : {1'b0, k};
    endfunction
    function automatic logic [23:0] absOf(input logic signed [23:0] v);
        return v[23] ? 24'(-v) : 24'(v);
    endfunction
    function automatic logic signed [23:0] halfSum(input logic signed [23:0] a,
                                                   input logic signed [23:0] b);
        logic signed [24:0] s;
        s = 25'(a) + 25'(b);
        return s[24:1];
    endfunction

    // register file
    logic [6:0]  cfg_r, cfg_nxt;
    logic [5:0]  modes_r, modes_nxt, mask_r, mask_nxt, status_r, status_nxt;
    logic [15:0] cycles_r, cycles_nxt, pWidth_r, pWidth_nxt, pRate_r, pRate_nxt;
    logic [23:0] noLoad_r, noLoad_nxt;
    logic [15:0] dur_r [4], dur_nxt [4];
    logic [23:0] level_r [4], level_nxt [4];
    logic [31:0] prdata_nxt;
    logic        pready_nxt, pslverr_nxt, apbWr, mapped;
    logic [5:0]  setBits, clrBits;
    // timing
    logic [3:0]  divCnt_r, divCnt_nxt;
    logic [9:0]  owrCnt_r, owrCnt_nxt;
    logic [15:0] cycCnt_r, cycCnt_nxt, nEff;
    logic        dclkTick, sampleStb, lowRateStb;
    // pins
    logic [1:0]  pinSync_r [3];
    logic [1:0]  pinLvl_r, pinLvl_nxt;
    logic        procClk_nxt;
    logic signed [23:0] latch_r [8], latch_nxt [8];
    logic signed [23:0] activePulse, reactivePulse, apparentPulse;
    logic signed [23:0] pinValue [3];
    logic [2:0]  pinEnergy, pinLevel, pinOut_nxt;
    logic [23:0] acc_r [3], acc_nxt [3];
    logic [15:0] width_r [3], width_nxt [3], pWidthEff;
    logic [39:0] prod [3];
    logic [24:0] accSum [3];
    logic        e1En;
    logic [1:0]  typeSel;
    // interrupt
    irq_state_e  irqState_r, irqState_nxt;
    logic        irqCnt_r, irqCnt_nxt, irqAssert, irqPin_nxt, pending;
    logic [3:0]  detFlag;

    assign apbWr = psel && penable && pready && pwrite;
    assign mapped = paddr[1:0] == 2'b00 && (paddr[7:5] == 3'b000
        || paddr[7:4] == PAGE_DUR || paddr[7:4] == PAGE_LEVEL || paddr == OFS_ACTIVE);

    always_comb begin
        cfg_nxt = cfg_r;
        modes_nxt = modes_r;
        cycles_nxt = cycles_r;
        noLoad_nxt = noLoad_r;
        pWidth_nxt = pWidth_r;
        pRate_nxt = pRate_r;
        mask_nxt = mask_r;
        dur_nxt = dur_r;
        level_nxt = level_r;
        clrBits = 6'h00;
        if (apbWr && mapped) begin
            unique case (paddr)
                OFS_CONFIG: cfg_nxt = pwdata[6:0];
                OFS_MODES:  modes_nxt = pwdata[5:0];
                OFS_CYCLES: cycles_nxt = pwdata[15:0];
                OFS_NOLOAD: noLoad_nxt = pwdata[23:0];
                OFS_PWIDTH: pWidth_nxt = pwdata[15:0];
                OFS_PRATE:  pRate_nxt = pwdata[15:0];
                OFS_STATUS: clrBits = pwdata[5:0];
                OFS_MASK:   mask_nxt = pwdata[5:0];
                default: begin
                    if (paddr[7:4] == PAGE_DUR)
                        dur_nxt[paddr[3:2]] = pwdata[15:0];
                    else if (paddr[7:4] == PAGE_LEVEL)
                        level_nxt[paddr[3:2]] = pwdata[23:0];
                end
            endcase
        end
        // a flag raised in the clearing cycle survives
        status_nxt = (status_r & ~clrBits) | setBits;
        pready_nxt = psel && !penable;
        pslverr_nxt = psel && !penable && !mapped;
        prdata_nxt = 32'h00000000;
        if (psel && !penable && mapped) begin
            unique case (paddr)
                OFS_CONFIG: prdata_nxt = {25'h0, cfg_r};
                OFS_MODES:  prdata_nxt = {26'h0, modes_r};
                OFS_CYCLES: prdata_nxt = {16'h0, cycles_r};
                OFS_NOLOAD: prdata_nxt = {8'h00, noLoad_r};
                OFS_PWIDTH: prdata_nxt = {16'h0, pWidth_r};
                OFS_PRATE:  prdata_nxt = {16'h0, pRate_r};
                OFS_STATUS: prdata_nxt = {26'h0, status_r};
                OFS_MASK:   prdata_nxt = {26'h0, mask_r};
                OFS_ACTIVE: prdata_nxt = {{8{activePulse[23]}}, activePulse};
                default: begin
                    if (paddr[7:4] == PAGE_DUR)
                        prdata_nxt = {16'h0, dur_r[paddr[3:2]]};
                    else
                        prdata_nxt = {8'h00, level_r[paddr[3:2]]};
                end
            endcase
        end
    end

    // divided clock, output sample and low-rate strobes
    always_comb begin
        dclkTick = {1'b0, divCnt_r} >= divisorOf(cfg_r[3:0]) - 5'h01;
        divCnt_nxt = dclkTick ? 4'h0 : divCnt_r + 4'h1;
        sampleStb = dclkTick && owrCnt_r == OWR_LAST;
        owrCnt_nxt = dclkTick ? owrCnt_r + 10'h001 : owrCnt_r;
        // too short a window is stretched rather than trusted
        nEff = (cycles_r < MIN_CYCLES) ? MIN_CYCLES : cycles_r;
        lowRateStb = sampleStb && cycCnt_r >= nEff - 16'h0001;
        cycCnt_nxt = lowRateStb ? 16'h0000 : cycCnt_r + 16'(sampleStb);
        latch_nxt = latch_r;
        if (lowRateStb) begin
            latch_nxt = '{active1, active2, apparent1, apparent2,
                          reactive1, reactive2, wideband1, wideband2};
        end
        pinLvl_nxt = pinLvl_r;
        for (int b = 0; b < 2; b++) begin
            if (pinSync_r[1][b] == pinSync_r[2][b])
                pinLvl_nxt[b] = pinSync_r[2][b];
        end
        procClk_nxt = cfg_r[CFG_NONINV] ? pinLvl_r[0] : !pinLvl_r[0];
    end

    // pulse value registers and pin source selection
    always_comb begin
        activePulse = halfSum(latch_r[0], latch_r[1]);
        apparentPulse = halfSum(latch_r[2], latch_r[3]);
        reactivePulse = halfSum(latch_r[4], latch_r[5]);
        if (absOf(activePulse) < noLoad_r)
            activePulse = 24'sh000000;
        if (absOf(reactivePulse) < noLoad_r)
            reactivePulse = 24'sh000000;
        e1En = modes_r[MODE_B_LSB +: 2] == 2'b11;
        typeSel = modes_r[MODE_A_LSB +: 2];
        pinEnergy = 3'b111;
        pinLevel = 3'b000;
        pinValue[0] = e1En ? latch_r[{typeSel, 1'b0}] : activePulse;
        pinValue[1] = latch_r[{typeSel, 1'b1}];
        pinValue[2] = reactivePulse;
        if (!e1En) begin
            unique case (modes_r[MODE_B_LSB +: 2])
                2'b00: begin
                    pinEnergy[1] = 1'b0;
                    pinLevel[1] = activePulse[23] | reactivePulse[23];
                end
                2'b01: pinValue[1] = apparentPulse;
                default: pinEnergy[1] = 1'b0;
            endcase
            unique case (modes_r[MODE_C_LSB +: 2])
                2'b00: pinValue[2] = reactivePulse;
                2'b01: begin
                    pinEnergy[2] = 1'b0;
                    pinLevel[2] = pinLvl_r[1];
                end
                2'b10: begin
                    pinEnergy[2] = 1'b0;
                    pinLevel[2] = volt1Sample[23];
                end
                2'b11: pinValue[2] = apparentPulse;
            endcase
        end else begin
            pinEnergy[2] = 1'b0;
            unique case (modes_r[MODE_C_LSB +: 2])
                2'b00: pinLevel[2] = pinLvl_r[1];
                2'b01: pinLevel[2] = pinValue[0][23] | pinValue[1][23];
                default: pinLevel[2] = 1'b0;
            endcase
        end
    end

    // per-pin accumulators; a zero width still gives one sample
    always_comb begin
        pWidthEff = (pWidth_r == 16'h0000) ? 16'h0001 : pWidth_r;
        for (int i = 0; i < 3; i++) begin
            prod[i] = absOf(pinValue[i]) * pRate_r;
            accSum[i] = {1'b0, acc_r[i]} + {1'b0, prod[i][39:16]};
            acc_nxt[i] = acc_r[i];
            width_nxt[i] = width_r[i];
            if (!pinEnergy[i]) begin
                acc_nxt[i] = 24'h000000;
                width_nxt[i] = 16'h0000;
            end else if (sampleStb) begin
                acc_nxt[i] = accSum[i][23:0];
                if (accSum[i][24])
                    width_nxt[i] = pWidthEff;
                else if (width_r[i] != 16'h0000)
                    width_nxt[i] = width_r[i] - 16'h0001;
            end
            pinOut_nxt[i] = !(pinEnergy[i] ? width_r[i] != 16'h0000 : pinLevel[i]);
        end
    end

    // interrupt pin
    always_comb begin
        setBits = {pinLvl_r[1], lowRateStb, detFlag};
        pending = |(status_r & mask_r);
        irqState_nxt = irqState_r;
        irqCnt_nxt = irqCnt_r;
        unique case (irqState_r)
            IRQ_IDLE: begin
                if (pending && dclkTick) begin
                    irqState_nxt = IRQ_PULSE;
                    irqCnt_nxt = 1'b0;
                end
            end
            IRQ_PULSE: begin
                if (dclkTick) begin
                    irqCnt_nxt = 1'b1;
                    if (irqCnt_r == IRQ_LAST)
                        irqState_nxt = IRQ_HELD;
                end
            end
            IRQ_HELD: begin
                if (!pending)
                    irqState_nxt = IRQ_IDLE;
            end
        endcase
        irqAssert = cfg_r[CFG_IRQ_PULSE_SELECT] ? irqState_r == IRQ_PULSE : pending;
        irqPin_nxt = cfg_r[CFG_IRQ_POLARITY_INVERT] ? irqAssert : !irqAssert;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_r <= RST_CONFIG;
            modes_r <= RST_MODES;
            cycles_r <= RST_CYCLES;
            noLoad_r <= RST_NOLOAD;
            pWidth_r <= RST_PWIDTH;
            pRate_r <= RST_PRATE;
            mask_r <= RST_MASK;
            status_r <= 6'h00;
            dur_r <= '{default: RST_DUR};
            level_r <= '{default: RST_LEVEL};
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            divCnt_r <= 4'h0;
            owrCnt_r <= 10'h000;
            cycCnt_r <= 16'h0000;
            latch_r <= '{default: 24'sh000000};
            pinSync_r <= '{default: 2'b00};
            pinLvl_r <= 2'b00;
            procClockOut <= 1'b0;
            acc_r <= '{default: 24'h000000};
            width_r <= '{default: 16'h0000};
            {pulsePinC_n, pulsePinB_n, pulsePinA_n} <= 3'b111;
            irqState_r <= IRQ_IDLE;
            irqCnt_r <= 1'b0;
            irqPin <= 1'b1;
        end else begin
            cfg_r <= cfg_nxt;
            modes_r <= modes_nxt;
            cycles_r <= cycles_nxt;
            noLoad_r <= noLoad_nxt;
            pWidth_r <= pWidth_nxt;
            pRate_r <= pRate_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            dur_r <= dur_nxt;
            level_r <= level_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            divCnt_r <= divCnt_nxt;
            owrCnt_r <= owrCnt_nxt;
            cycCnt_r <= cycCnt_nxt;
            latch_r <= latch_nxt;
            pinSync_r <= '{{powerFailMonitor, crystalInput}, pinSync_r[0], pinSync_r[1]};
            pinLvl_r <= pinLvl_nxt;
            procClockOut <= procClk_nxt;
            acc_r <= acc_nxt;
            width_r <= width_nxt;
            {pulsePinC_n, pulsePinB_n, pulsePinA_n} <= pinOut_nxt;
            irqState_r <= irqState_nxt;
            irqCnt_r <= irqCnt_nxt;
            irqPin <= irqPin_nxt;
        end
    end

    // voltage1, voltage2, current1, current2 detectors
    sag_fault_detect u_det0 (.clk_sys(clk_sys), .rst(rst), .sampleStb(sampleStb),
        .sample(volt1Sample), .threshold(level_r[0]), .duration(dur_r[0]),
        .faultSet(detFlag[0]));
    sag_fault_detect u_det1 (.clk_sys(clk_sys), .rst(rst), .sampleStb(sampleStb),
        .sample(volt2Sample), .threshold(level_r[1]), .duration(dur_r[1]),
        .faultSet(detFlag[1]));
    sag_fault_detect u_det2 (.clk_sys(clk_sys), .rst(rst), .sampleStb(sampleStb),
        .sample(curr1Sample), .threshold(level_r[2]), .duration(dur_r[2]),
        .faultSet(detFlag[2]));
    sag_fault_detect u_det3 (.clk_sys(clk_sys), .rst(rst), .sampleStb(sampleStb),
        .sample(curr2Sample), .threshold(level_r[3]), .duration(dur_r[3]),
        .faultSet(detFlag[3]));

    sequence irqStart;
        irqState_r == IRQ_IDLE ##1 irqState_r == IRQ_PULSE;
    endsequence

    div_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
        dclkTick |=> divCnt_r == 4'h0)
        else $error("divider did not restart after tick");
    irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(cfg_r[CFG_IRQ_PULSE_SELECT]) |-> irqPin == ($past(cfg_r[CFG_IRQ_POLARITY_INVERT]) ~^ $past(pending)))
        else $error("irq level pin wrong");
    irq_pulse_a: assert property (@(posedge clk_sys) disable iff (rst)
        irqState_r == IRQ_PULSE && !(dclkTick && irqCnt_r) |=> irqState_r == IRQ_PULSE)
        else $error("irq pulse ended early");
    irq_start_a: assert property (@(posedge clk_sys) disable iff (rst)
        irqStart |-> $past(pending, 1) && $past(dclkTick, 1))
        else $error("irq pulse without cause");
    no_load_a: assert property (@(posedge clk_sys) disable iff (rst)
        activePulse != 24'sh000000 |-> absOf(activePulse) >= noLoad_r)
        else $error("active pulse below threshold");
    steady_pin_a: assert property (@(posedge clk_sys) disable iff (rst)
        !pinEnergy[2] |=> pulsePinC_n == !$past(pinLevel[2]))
        else $error("steady pin not following level");
    width_load_a: assert property (@(posedge clk_sys) disable iff (rst)
        sampleStb && pinEnergy[0] && accSum[0][24] |=> width_r[0] == $past(pWidthEff))
        else $error("pulse width not loaded");
    window_min_a: assert property (@(posedge clk_sys) disable iff (rst)
        lowRateStb |-> cycCnt_r >= MIN_CYCLES - 16'h0001)
        else $error("window shorter than minimum");
    status_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        detFlag[0] |=> status_r[0])
        else $error("sag flag lost");
endmodule

/* tb/pulse_monitor.sv */
// far-side counter model watching the interrupt pin and pulse pin A
`timescale 1ns/100ps
module pulse_monitor (
    // clock
    input  wire logic clk_sys,
    // observed pins
    input  wire logic irqPin,
    input  wire logic pulsePinA_n,
    // tallies
    output int        irqLow,
    output int        widthA
);
    int run;
    // a counter only sees levels at clock edges, as a sampling input would
    always @(posedge clk_sys) begin
        if (irqPin === 1'b0) irqLow <= irqLow + 1;
        if (pulsePinA_n === 1'b0) run <= run + 1;
        else if (run != 0) begin
            widthA <= run;
            run    <= 0;
        end
    end
endmodule

/* tb/energy_output_stage_bench.sv */
// self-checking bench for the energy output stage
`timescale 1ns/100ps
module energy_output_stage_bench;
    import energy_out_pkg::*;
    logic               clk_sys, rst, psel, penable, pwrite, crystalInput, powerFailMonitor, err;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, rd;
    logic signed [23:0] act, rea, volt;
    wire  [31:0]        prdata;
    wire                pready, pslverr, procClockOut, irqPin;
    wire                pulsePinA_n, pulsePinB_n, pulsePinC_n;
    int                 errors, checked, irqBase, irqLow, widthA;
    energy_output_stage DUT (.clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .crystalInput, .powerFailMonitor, .procClockOut,
        .pulsePinA_n, .pulsePinB_n, .pulsePinC_n, .irqPin, .active1(act), .active2(act),
        .apparent1(act), .apparent2(act), .reactive1(rea), .reactive2(rea), .wideband1(rea),
        .wideband2(rea), .volt1Sample(volt), .volt2Sample(volt), .curr1Sample(volt),
        .curr2Sample(volt));
    pulse_monitor mon (.clk_sys, .irqPin, .pulsePinA_n, .irqLow, .widthA);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // request held until pready is seen high at a rising edge; data taken there
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) errors++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check_registers();
        apb(OFS_CONFIG, 1'b0, 32'h0);
        chk(rd, 32'(RST_CONFIG));
        apb(OFS_CYCLES, 1'b0, 32'h0);
        chk(rd, 32'h00000FA0);
        apb(OFS_PWIDTH, 1'b0, 32'h0);
        chk(rd, 32'h00000001);
        apb(8'h80, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic check_clock();
        crystalInput <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(32'(procClockOut), 32'h0);
        apb(OFS_CONFIG, 1'b1, 32'h11);
        repeat (8) @(posedge clk_sys);
        chk(32'(procClockOut), 32'h1);
        apb(OFS_CONFIG, 1'b1, 32'h01);
    endtask
    task automatic check_irq();
        apb(OFS_MASK, 1'b1, 32'h20);
        powerFailMonitor <= 1'b1;
        repeat (10) @(posedge clk_sys);
        chk(32'(irqPin), 32'h0);
        apb(OFS_CONFIG, 1'b1, 32'h21);
        repeat (4) @(posedge clk_sys);
        chk(32'(irqPin), 32'h1);
        powerFailMonitor <= 1'b0;
        repeat (10) @(posedge clk_sys);
        apb(OFS_STATUS, 1'b1, 32'h20);
        repeat (4) @(posedge clk_sys);
        chk(32'(irqPin), 32'h0);
        apb(OFS_CONFIG, 1'b1, 32'h42);
        repeat (4) @(posedge clk_sys);
        irqBase = irqLow;
        powerFailMonitor <= 1'b1;
        repeat (40) @(posedge clk_sys);
        chk(32'(irqLow - irqBase), 32'd4);
        powerFailMonitor <= 1'b0;
        repeat (10) @(posedge clk_sys);
        apb(OFS_STATUS, 1'b1, 32'h20);
        apb(OFS_MASK, 1'b1, 32'h0);
        apb(OFS_CONFIG, 1'b1, 32'h01);
    endtask
    task automatic check_energy();
        act <= 24'sh400000;
        apb(OFS_CYCLES, 1'b1, 32'd10);
        apb(OFS_PRATE, 1'b1, 32'h0000FFFF);
        apb(OFS_PWIDTH, 1'b1, 32'h2);
        apb(8'h20, 1'b1, 32'd10);
        apb(8'h30, 1'b1, 32'h00100000);
        repeat (12288) @(posedge clk_sys);
        apb(OFS_ACTIVE, 1'b0, 32'h0);
        chk(rd, 32'h00400000);
        apb(OFS_STATUS, 1'b0, 32'h0);
        chk(rd & 32'h0000000F, 32'h1);
        repeat (8192) @(posedge clk_sys);
        chk(32'(widthA), 32'd2048);
        chk(32'(pulsePinB_n), 32'h1);
        act <= -24'sh400000;
        repeat (11264) @(posedge clk_sys);
        chk(32'(pulsePinB_n), 32'h0);
        apb(OFS_ACTIVE, 1'b0, 32'h0);
        chk(rd, 32'hFFC00000);
        apb(OFS_MODES, 1'b1, 32'h08);
        repeat (4) @(posedge clk_sys);
        chk(32'(pulsePinB_n), 32'h1);
        // channel mode: pin c shows the sign of the negative active channels
        apb(OFS_MODES, 1'b1, 32'h1C);
        repeat (4) @(posedge clk_sys);
        chk(32'(pulsePinC_n), 32'h0);
        apb(OFS_NOLOAD, 1'b1, 32'h007FFFFF);
        repeat (11264) @(posedge clk_sys);
        apb(OFS_ACTIVE, 1'b0, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic summarize();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // run needs about 43k cycles; the margin covers slow apb answers
    initial begin
        repeat (80000) @(posedge clk_sys);
        errors++;
        summarize();
    end
    initial begin
        {rst, psel, penable, pwrite, crystalInput, powerFailMonitor} = 6'b100000;
        {paddr, pwdata, act, rea, volt} = {8'h0, 32'h0, 24'sh0, 24'sh010000, 24'sh001000};
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        check_registers();
        check_clock();
        check_irq();
        check_energy();
        summarize();
    end
endmodule
